/* core/acc_params.svh */
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Machine cycle length in core clocks and the last count of the divider.
`define ACC_MC_DIV 4'd15
`define ACC_MC_LAST 4'd14
`define ACC_MC_ZERO 4'd0
`define ACC_MC_ONE 4'd1

// Reset values.
`define ACC_RST_BYTE 8'h00
`define ACC_RST_SEL 3'h0

// Whole-byte opcodes of the accumulator group.
`define ACC_OP_ADD_IMM 8'h03
`define ACC_OP_SUMC_IMM 8'h13
`define ACC_OP_AND_IMM 8'h53
`define ACC_OP_OR_IMM 8'h43
`define ACC_OP_XOR_IMM 8'hd3
`define ACC_OP_INV 8'h37
`define ACC_OP_ZERO 8'h27
`define ACC_OP_DFIX 8'h57
`define ACC_OP_DOWN 8'h07
`define ACC_OP_INC 8'h17
`define ACC_OP_ROL 8'he7
`define ACC_OP_ROLC 8'hf7
`define ACC_OP_ROR 8'h77
`define ACC_OP_RORC 8'h67
`define ACC_OP_SWAP 8'h47

// Register-direct patterns, opcode bits 7 to 3.
`define ACC_RG_ADD 5'h0d
`define ACC_RG_SUMC 5'h0f
`define ACC_RG_AND 5'h0b
`define ACC_RG_OR 5'h09
`define ACC_RG_XOR 5'h1b

// Register-indirect patterns, opcode bits 7 to 1.
`define ACC_IN_ADD 7'h30
`define ACC_IN_SUMC 7'h38
`define ACC_IN_AND 7'h28
`define ACC_IN_OR 7'h20
`define ACC_IN_XOR 7'h68

// Decimal adjust limits and corrections.
`define ACC_BCD_LIM 4'h9
`define ACC_DA_LO_FIX 9'h006
`define ACC_DA_HI_FIX 9'h060
`define ACC_Z9 9'h000
`define ACC_ONE8 8'h01

`endif

/* core/acc_pkg.sv */
package acc_pkg;

  // Operation selected for the arithmetic and logic unit.
  typedef enum logic [3:0] {
    ACC_ALU_ADD = 4'h0,
    ACC_ALU_SUMC = 4'h1,
    ACC_ALU_AND = 4'h2,
    ACC_ALU_OR = 4'h3,
    ACC_ALU_XOR = 4'h4,
    ACC_ALU_INV = 4'h5,
    ACC_ALU_ZERO = 4'h6,
    ACC_ALU_DFIX = 4'h7,
    ACC_ALU_DOWN = 4'h8,
    ACC_ALU_INC = 4'h9,
    ACC_ALU_ROL = 4'ha,
    ACC_ALU_ROLC = 4'hb,
    ACC_ALU_ROR = 4'hc,
    ACC_ALU_RORC = 4'hd,
    ACC_ALU_SWAP = 4'he
  } acc_alu_op_t;

  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    ACC_S_IDLE = 5'b00001,
    ACC_S_IMM = 5'b00010,
    ACC_S_REG = 5'b00100,
    ACC_S_MEM = 5'b01000,
    ACC_S_EXEC = 5'b10000
  } acc_state_t;

endpackage

/* core/acc_alu_if.sv */
`timescale 1ns/1ps

// Operands, flags and results between the sequencer and the unit.
interface acc_alu_if;
  acc_pkg::acc_alu_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cy_in;
  logic hc_in;
  logic [7:0] res;
  logic cy_o;
  logic hc_o;
  logic cy_we;
  logic hc_we;

  modport core (output op, a, b, cy_in, hc_in, input res, cy_o, hc_o, cy_we, hc_we);
  modport alu (input op, a, b, cy_in, hc_in, output res, cy_o, hc_o, cy_we, hc_we);
endinterface

/* core/acc_alu.sv */
`timescale 1ns/1ps
`include "acc_params.svh"

// Purely combinational; the sequencer registers every result.
module acc_alu (
  acc_alu_if.alu alu
);

  // One case per operation, ADD and SUMC sharing one; flags stay put unless a write enable is raised.
  always_comb begin
    logic [8:0] s9;
    logic [8:0] t9;
    logic [8:0] u9;
    logic [4:0] lo5;
    logic cin;
    logic fix_hi;
    s9 = `ACC_Z9;
    t9 = `ACC_Z9;
    u9 = `ACC_Z9;
    lo5 = 5'h00;
    cin = (alu.op == acc_pkg::ACC_ALU_SUMC) ? alu.cy_in : 1'b0;
    fix_hi = 1'b0;
    alu.res = alu.a;
    alu.cy_o = alu.cy_in;
    alu.hc_o = alu.hc_in;
    alu.cy_we = 1'b0;
    alu.hc_we = 1'b0;
    case (alu.op)
      acc_pkg::ACC_ALU_ADD, acc_pkg::ACC_ALU_SUMC: begin
        s9 = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, cin};
        lo5 = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, cin};
        alu.res = s9[7:0];
        alu.cy_o = s9[8];
        alu.hc_o = lo5[4];
        alu.cy_we = 1'b1;
        alu.hc_we = 1'b1;
      end
      acc_pkg::ACC_ALU_AND: alu.res = alu.a & alu.b;
      acc_pkg::ACC_ALU_OR: alu.res = alu.a | alu.b;
      acc_pkg::ACC_ALU_XOR: alu.res = alu.a ^ alu.b;
      acc_pkg::ACC_ALU_INV: alu.res = ~alu.a;
      acc_pkg::ACC_ALU_ZERO: alu.res = `ACC_RST_BYTE;
      acc_pkg::ACC_ALU_DFIX: begin
        t9 = {1'b0, alu.a};
        if ((alu.a[3:0] > `ACC_BCD_LIM) || alu.hc_in) begin
          t9 = t9 + `ACC_DA_LO_FIX;
        end
        fix_hi = (t9[7:4] > `ACC_BCD_LIM) || t9[8] || alu.cy_in;
        u9 = {1'b0, t9[7:0]} + (fix_hi ? `ACC_DA_HI_FIX : `ACC_Z9);
        alu.res = u9[7:0];
        alu.cy_o = fix_hi;
        alu.cy_we = 1'b1;
      end
      acc_pkg::ACC_ALU_DOWN: alu.res = alu.a - `ACC_ONE8;
      acc_pkg::ACC_ALU_INC: alu.res = alu.a + `ACC_ONE8;
      acc_pkg::ACC_ALU_ROL: alu.res = {alu.a[6:0], alu.a[7]};
      acc_pkg::ACC_ALU_ROLC: begin
        alu.res = {alu.a[6:0], alu.cy_in};
        alu.cy_o = alu.a[7];
        alu.cy_we = 1'b1;
      end
      acc_pkg::ACC_ALU_ROR: alu.res = {alu.a[0], alu.a[7:1]};
      acc_pkg::ACC_ALU_RORC: begin
        alu.res = {alu.cy_in, alu.a[7:1]};
        alu.cy_o = alu.a[0];
        alu.cy_we = 1'b1;
      end
      acc_pkg::ACC_ALU_SWAP: alu.res = {alu.a[3:0], alu.a[7:4]};
      default: alu.res = alu.a;
    endcase
  end

endmodule

/* core/acc_exec.sv */
`timescale 1ns/1ps
`include "acc_params.svh"

module acc_exec (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  input wire logic [7:0] reg_data,
  input wire logic [7:0] dm_data,
  output logic [2:0] working_register_select,
  output logic [7:0] dm_addr,
  output logic [7:0] acc_out,
  output logic cy_out,
  output logic half_byte_carry_flag,
  output logic mc_tick,
  output logic op_taken,
  output logic op_done,
  output logic op_unknown
);

  ////////////////////////////////////////////////////////////////////////
  // Machine cycle divider.

  logic [3:0] mc_cnt_r;
  logic [3:0] mc_cnt_nxt;
  logic mc_en;

  // One enable pulse every machine cycle; all fetch handshakes wait for it.
  assign mc_en = (mc_cnt_r == `ACC_MC_LAST);
  assign mc_cnt_nxt = mc_en ? `ACC_MC_ZERO : (mc_cnt_r + `ACC_MC_ONE);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mc_cnt_r <= `ACC_MC_ZERO;
    end else begin
      mc_cnt_r <= mc_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Opcode decode.

  logic is_add_imm;
  logic is_sumc_imm;
  logic is_and_imm;
  logic is_or_imm;
  logic is_xor_imm;
  logic is_add_reg;
  logic is_sumc_reg;
  logic is_and_reg;
  logic is_or_reg;
  logic is_xor_reg;
  logic is_add_ind;
  logic is_sumc_ind;
  logic is_and_ind;
  logic is_or_ind;
  logic is_xor_ind;
  logic dec_imm;
  logic dec_reg;
  logic dec_ind;
  logic dec_acc_only;
  logic dec_known;
  acc_pkg::acc_alu_op_t dec_op;

  assign is_add_imm = (op_byte == `ACC_OP_ADD_IMM);
  assign is_sumc_imm = (op_byte == `ACC_OP_SUMC_IMM);
  assign is_and_imm = (op_byte == `ACC_OP_AND_IMM);
  assign is_or_imm = (op_byte == `ACC_OP_OR_IMM);
  assign is_xor_imm = (op_byte == `ACC_OP_XOR_IMM);

  // Register forms, low three bits pick the register.
  assign is_add_reg = (op_byte[7:3] == `ACC_RG_ADD);
  assign is_sumc_reg = (op_byte[7:3] == `ACC_RG_SUMC);
  assign is_and_reg = (op_byte[7:3] == `ACC_RG_AND);
  assign is_or_reg = (op_byte[7:3] == `ACC_RG_OR);
  assign is_xor_reg = (op_byte[7:3] == `ACC_RG_XOR);

  // Indirect forms, bit 0 picks pointer register.
  assign is_add_ind = (op_byte[7:1] == `ACC_IN_ADD);
  assign is_sumc_ind = (op_byte[7:1] == `ACC_IN_SUMC);
  assign is_and_ind = (op_byte[7:1] == `ACC_IN_AND);
  assign is_or_ind = (op_byte[7:1] == `ACC_IN_OR);
  assign is_xor_ind = (op_byte[7:1] == `ACC_IN_XOR);

  assign dec_imm = is_add_imm | is_sumc_imm | is_and_imm | is_or_imm | is_xor_imm;
  assign dec_reg = is_add_reg | is_sumc_reg | is_and_reg | is_or_reg | is_xor_reg;
  assign dec_ind = is_add_ind | is_sumc_ind | is_and_ind | is_or_ind | is_xor_ind;

  // Accumulator-only opcodes need no operand fetch.
  assign dec_acc_only = (op_byte == `ACC_OP_INV) | (op_byte == `ACC_OP_ZERO) |
                        (op_byte == `ACC_OP_DFIX) | (op_byte == `ACC_OP_DOWN) |
                        (op_byte == `ACC_OP_INC) | (op_byte == `ACC_OP_ROL) |
                        (op_byte == `ACC_OP_ROLC) | (op_byte == `ACC_OP_ROR) |
                        (op_byte == `ACC_OP_RORC) | (op_byte == `ACC_OP_SWAP);
  assign dec_known = dec_imm | dec_reg | dec_ind | dec_acc_only;

  assign dec_op =
    (is_add_imm | is_add_reg | is_add_ind) ? acc_pkg::ACC_ALU_ADD :
    (is_sumc_imm | is_sumc_reg | is_sumc_ind) ? acc_pkg::ACC_ALU_SUMC :
    (is_and_imm | is_and_reg | is_and_ind) ? acc_pkg::ACC_ALU_AND :
    (is_or_imm | is_or_reg | is_or_ind) ? acc_pkg::ACC_ALU_OR :
    (is_xor_imm | is_xor_reg | is_xor_ind) ? acc_pkg::ACC_ALU_XOR :
    (op_byte == `ACC_OP_INV) ? acc_pkg::ACC_ALU_INV :
    (op_byte == `ACC_OP_ZERO) ? acc_pkg::ACC_ALU_ZERO :
    (op_byte == `ACC_OP_DFIX) ? acc_pkg::ACC_ALU_DFIX :
    (op_byte == `ACC_OP_DOWN) ? acc_pkg::ACC_ALU_DOWN :
    (op_byte == `ACC_OP_INC) ? acc_pkg::ACC_ALU_INC :
    (op_byte == `ACC_OP_ROL) ? acc_pkg::ACC_ALU_ROL :
    (op_byte == `ACC_OP_ROLC) ? acc_pkg::ACC_ALU_ROLC :
    (op_byte == `ACC_OP_ROR) ? acc_pkg::ACC_ALU_ROR :
    (op_byte == `ACC_OP_RORC) ? acc_pkg::ACC_ALU_RORC :
    acc_pkg::ACC_ALU_SWAP;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer.

  acc_pkg::acc_state_t state_r;
  acc_pkg::acc_state_t state_nxt;
  acc_pkg::acc_alu_op_t alu_op_r;
  logic ind_r;
  logic take_op;
  logic take_imm;
  logic exec_now;

  // An opcode is only taken on the machine-cycle pulse while idle.
  assign take_op = (state_r == acc_pkg::ACC_S_IDLE) && mc_en && op_valid;
  // The immediate byte arrives one machine cycle later, so two cycles total.
  assign take_imm = (state_r == acc_pkg::ACC_S_IMM) && mc_en && op_valid;
  assign exec_now = (state_r == acc_pkg::ACC_S_EXEC);

  // Next-state choice; register and indirect operand fetch take at most two core clocks.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      acc_pkg::ACC_S_IDLE: begin
        if (take_op && dec_imm) begin
          state_nxt = acc_pkg::ACC_S_IMM;
        end else if (take_op && (dec_reg || dec_ind)) begin
          state_nxt = acc_pkg::ACC_S_REG;
        end else if (take_op && dec_acc_only) begin
          state_nxt = acc_pkg::ACC_S_EXEC;
        end
      end
      acc_pkg::ACC_S_IMM: begin
        if (take_imm) begin
          state_nxt = acc_pkg::ACC_S_EXEC;
        end
      end
      acc_pkg::ACC_S_REG: begin
        state_nxt = ind_r ? acc_pkg::ACC_S_MEM : acc_pkg::ACC_S_EXEC;
      end
      acc_pkg::ACC_S_MEM: state_nxt = acc_pkg::ACC_S_EXEC;
      acc_pkg::ACC_S_EXEC: state_nxt = acc_pkg::ACC_S_IDLE;
      default: state_nxt = acc_pkg::ACC_S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= acc_pkg::ACC_S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Latch the decoded operation and its addressing form with the opcode.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      alu_op_r <= acc_pkg::ACC_ALU_ADD;
      ind_r <= 1'b0;
    end else if (take_op) begin
      alu_op_r <= dec_op;
      ind_r <= dec_ind;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operand fetch.

  logic [7:0] operand_r;
  logic [7:0] operand_nxt;
  logic [2:0] rsel_nxt;
  logic [7:0] dm_addr_nxt;

  // Register number, or pointer R0/R1 for indirect.
  assign rsel_nxt = dec_ind ? {2'b00, op_byte[0]} : op_byte[2:0];
  // Pointer register contents address data memory.
  assign dm_addr_nxt = (state_r == acc_pkg::ACC_S_REG && ind_r) ? reg_data : dm_addr;
  assign operand_nxt = take_imm ? op_byte :
                       (state_r == acc_pkg::ACC_S_REG && !ind_r) ? reg_data :
                       (state_r == acc_pkg::ACC_S_MEM) ? dm_data : operand_r;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      working_register_select <= `ACC_RST_SEL;
      dm_addr <= `ACC_RST_BYTE;
      operand_r <= `ACC_RST_BYTE;
    end else begin
      if (take_op && (dec_reg || dec_ind)) begin
        working_register_select <= rsel_nxt;
      end
      dm_addr <= dm_addr_nxt;
      operand_r <= operand_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Execute and write back.

  acc_alu_if alu_bus ();

  assign alu_bus.op = alu_op_r;
  assign alu_bus.a = acc_out;
  assign alu_bus.b = operand_r;
  assign alu_bus.cy_in = cy_out;
  assign alu_bus.hc_in = half_byte_carry_flag;

  acc_alu u_alu (
    .alu(alu_bus)
  );

  logic [7:0] acc_nxt;
  logic cy_nxt;
  logic hc_nxt;

  // Flags only move when the unit asks; logic ops leave carry alone.
  assign acc_nxt = exec_now ? alu_bus.res : acc_out;
  // Carry written only for sums, adjust, carry rotates.
  assign cy_nxt = (exec_now && alu_bus.cy_we) ? alu_bus.cy_o : cy_out;
  assign hc_nxt = (exec_now && alu_bus.hc_we) ? alu_bus.hc_o : half_byte_carry_flag;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      acc_out <= `ACC_RST_BYTE;
      cy_out <= 1'b0;
      half_byte_carry_flag <= 1'b0;
    end else begin
      acc_out <= acc_nxt;
      cy_out <= cy_nxt;
      half_byte_carry_flag <= hc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status pulses toward the fetch unit.

  logic bad_nxt;

  // Opcodes outside this group are refused and left to other units.
  assign bad_nxt = take_op && !dec_known;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mc_tick <= 1'b0;
      op_taken <= 1'b0;
      op_done <= 1'b0;
      op_unknown <= 1'b0;
    end else begin
      mc_tick <= mc_en;
      op_taken <= take_op && dec_known;
      op_done <= exec_now;
      op_unknown <= bad_nxt;
    end
  end

endmodule

/* test/acc_ref_pkg.sv */
package acc_ref_pkg;

  // Class of a byte: 0 foreign, 1 accumulator only, 2 register, 3 indirect, 4 immediate.
  function automatic int kind(logic [7:0] op);
    casez (op)
      8'h03, 8'h13, 8'h53, 8'h43, 8'hd3: kind = 4;
      8'b01101???, 8'b01111???, 8'b01011???, 8'b01001???, 8'b11011???: kind = 2;
      8'b0110000?, 8'b0111000?, 8'b0101000?, 8'b0100000?, 8'b1101000?: kind = 3;
      8'h37, 8'h27, 8'h57, 8'h07, 8'h17, 8'he7, 8'hf7, 8'h77, 8'h67, 8'h47: kind = 1;
      default: kind = 0;
    endcase
  endfunction

  // Every addition form sits in rows 0, 1, 6 and 7 of the opcode map.
  function automatic bit is_add(logic [7:0] op);
    is_add = kind(op) > 1 && (op[7:5] == 3'h3 || op[7:5] == 3'h0);
  endfunction

  // Operations that leave the carry alone.
  function automatic bit keep_cy(logic [7:0] op);
    keep_cy = kind(op) != 0 && !is_add(op) && !(op inside {8'h57, 8'hf7, 8'h67});
  endfunction

  // Result as {carry, nibble carry, accumulator}; b is the fetched operand.
  function automatic logic [9:0] step(logic [7:0] op, logic [7:0] a, logic [7:0] b,
                                      logic c, logic h);
    logic [8:0] s;
    logic [4:0] l;
    logic x;
    step = {c, h, a};
    x = op[4] & c;
    s = {1'b0, a} + b + x;
    l = a[3:0] + b[3:0] + x;
    if (is_add(op)) step = {s[8], l[4], s[7:0]};
    casez (op)
      8'h53, 8'b01011???, 8'b0101000?: step[7:0] = a & b;
      8'h43, 8'b01001???, 8'b0100000?: step[7:0] = a | b;
      8'hd3, 8'b11011???, 8'b1101000?: step[7:0] = a ^ b;
      8'h37: step[7:0] = ~a;
      8'h27: step[7:0] = 8'h00;
      8'h07: step[7:0] = a - 8'h01;
      8'h17: step[7:0] = a + 8'h01;
      8'he7: step[7:0] = {a[6:0], a[7]};
      8'hf7: step = {a[7], h, a[6:0], c};
      8'h77: step[7:0] = {a[0], a[7:1]};
      8'h67: step = {a[0], h, c, a[7:1]};
      8'h47: step[7:0] = {a[3:0], a[7:4]};
      8'h57: begin
        s = {1'b0, a} + ((a[3:0] > 4'h9 || h) ? 9'h006 : 9'h000);
        x = s[8] || c || s[7:4] > 4'h9;
        step = {x, h, s[7:0] + (x ? 8'h60 : 8'h00)};
      end
      default: ;
    endcase
  endfunction

endpackage

/* test/acc_store_model.sv */
`timescale 1ns/1ps

// Working registers and data memory; reads are combinational, as the unit expects.
module acc_store_model (
  input wire logic [2:0] working_register_select,
  input wire logic [7:0] dm_addr,
  output logic [7:0] reg_data,
  output logic [7:0] dm_data
);
  logic [7:0] regs [8];
  logic [7:0] mem [256];

  assign reg_data = regs[working_register_select];
  assign dm_data = mem[dm_addr];
endmodule

/* test/acc_exec_properties.sv */
`timescale 1ns/1ps

// Cycle counts and flag effects seen at the execute unit's ports.
module acc_exec_properties (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] op_byte,
  input wire logic [2:0] working_register_select,
  input wire logic [7:0] acc_out,
  input wire logic cy_out,
  input wire logic half_byte_carry_flag,
  input wire logic mc_tick,
  input wire logic op_taken,
  input wire logic op_done
);
  logic [7:0] op_q;
  logic [7:0] op_h;
  logic [7:0] acc_q;
  int k;

  // The opcode of the taking edge is kept until its result lands.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      op_q <= 8'h00;
      op_h <= 8'h00;
      acc_q <= 8'h00;
    end else begin
      op_q <= op_byte;
      acc_q <= acc_out;
      if (op_taken) op_h <= op_q;
    end
  end
  assign k = acc_ref_pkg::kind(op_q);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////
  tick_period_a: assert property (mc_tick |=> !mc_tick [*8] ##1 !mc_tick [*6] ##1 mc_tick)
    else $error("machine cycle spacing wrong");
  taken_on_tick_a: assert property (op_taken |-> mc_tick)
    else $error("opcode taken off a machine cycle");
  acc_latency_a: assert property (op_taken && k == 1 |=> op_done)
    else $error("accumulator op not done in one cycle");
  reg_latency_a: assert property (op_taken && k == 2 |=> !op_done ##1 op_done)
    else $error("register op latency wrong");
  ind_latency_a: assert property (op_taken && k == 3 |=> !op_done [*2] ##1 op_done)
    else $error("indirect op latency wrong");
  imm_latency_a: assert property (op_taken && k == 4 |=> !op_done [*8] ##1 !op_done [*7] ##1 op_done)
    else $error("immediate op latency wrong");
  reg_select_a: assert property (op_taken && k == 2 |-> working_register_select == op_q[2:0])
    else $error("wrong register selected");
  carry_kept_a: assert property (op_done && acc_ref_pkg::keep_cy(op_h) |-> $stable(cy_out))
    else $error("carry changed by a carry-neutral op");
  nibble_kept_a: assert property (op_done && !acc_ref_pkg::is_add(op_h) |-> $stable(half_byte_carry_flag))
    else $error("nibble carry changed outside an addition");
  rotate_value_a: assert property (op_done && op_h == 8'he7 |-> acc_out == {acc_q[6:0], acc_q[7]})
    else $error("left rotate result wrong");

  // Main traffic classes.
  cover property (op_taken && k == 4);
  cover property (op_done && op_h == 8'h57);
  cover property (op_taken && k == 3);
endmodule

bind acc_exec acc_exec_properties i_props (.core_clk, .resetn, .op_byte,
  .working_register_select, .acc_out, .cy_out, .half_byte_carry_flag, .mc_tick,
  .op_taken, .op_done);

/* test/tb.sv */
`timescale 1ns/1ps

module tb;
  logic core_clk;
  logic resetn;
  logic op_valid;
  logic [7:0] op_byte;
  logic [7:0] reg_data;
  logic [7:0] dm_data;
  logic [2:0] working_register_select;
  logic [7:0] dm_addr;
  logic [7:0] acc_out;
  logic cy_out;
  logic half_byte_carry_flag;
  logic mc_tick;
  logic op_taken;
  logic op_done;
  logic op_unknown;
  logic [9:0] model;
  int fails;
  int num_checks;

  acc_exec i_dut (.core_clk, .resetn, .op_valid, .op_byte, .reg_data, .dm_data,
    .working_register_select, .dm_addr, .acc_out, .cy_out, .half_byte_carry_flag,
    .mc_tick, .op_taken, .op_done, .op_unknown);
  acc_store_model i_mem (.working_register_select, .dm_addr, .reg_data, .dm_data);

  // Core clock at 40 MHz.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Ten cycles of reset; mc_tick, op_done, both carries and acc_out must read zero at the end.
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (10) @(posedge core_clk);
    check("reset state", 16'({mc_tick, op_done, cy_out, half_byte_carry_flag, acc_out}), 16'h0000);
    resetn <= 1'b1;
    model = 10'h000;
  endtask

  // Holds the opcode until it is taken, then the immediate byte until the result lands.
  task automatic run(logic [7:0] op, logic [7:0] imm);
    int n;
    int k;
    logic [7:0] b;
    k = acc_ref_pkg::kind(op);
    b = k == 4 ? imm : k == 2 ? i_mem.regs[op[2:0]] : i_mem.mem[i_mem.regs[op[0]]];
    n = 0;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_byte <= op;
    do begin
      @(posedge core_clk);
      n++;
    end while (op_taken !== 1'b1 && op_unknown !== 1'b1 && n < 40);
    check("foreign flag", 16'(op_unknown), 16'(k == 0));
    op_byte <= imm;
    op_valid <= k == 4;
    if (k != 0) begin
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (op_done !== 1'b1 && n < 40);
      model = acc_ref_pkg::step(op, model[7:0], b, model[9], model[8]);
      check("latency", 16'(n), 16'(k == 4 ? 16 : k));
      op_valid <= 1'b0;
    end
    check("acc and flags", 16'({cy_out, half_byte_carry_flag, acc_out}), 16'(model));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence: every byte value, packed decimal sums, an abort, then random traffic.
  initial begin
    logic [15:0] bcd [4];
    bcd = '{16'h9901, 16'h3849, 16'h0909, 16'h9090};
    fails = 0;
    num_checks = 0;
    resetn = 1'b0;
    op_valid = 1'b0;
    op_byte = 8'h00;
    void'($urandom(32'hb573));
    for (int i = 0; i < 8; i++) i_mem.regs[i] = 8'($urandom);
    for (int i = 0; i < 256; i++) i_mem.mem[i] = 8'($urandom);
    do_reset();
    for (int i = 0; i < 256; i++) run(8'(i), 8'($urandom));
    $display("test opcode sweep done");
    for (int i = 0; i < 4; i++) begin
      run(8'h27, 8'h00);
      run(8'h03, bcd[i][15:8]);
      run(8'h03, bcd[i][7:0]);
      run(8'h57, 8'h00);
    end
    $display("test decimal adjust done");
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_byte <= 8'h13;
    repeat (17) @(posedge core_clk);
    op_valid <= 1'b0;
    do_reset();
    run(8'h07, 8'h00);
    run(8'h17, 8'h00);
    $display("test reset mid-op done");
    for (int i = 0; i < 200; i++) run(8'($urandom), 8'($urandom));
    $display("test random traffic done");
    conclude();
  end

  // Cut a hang short well past the expected run length.
  initial begin
    #2000000;
    fails++;
    conclude();
  end
endmodule
